// [operating_mode_register.sv]
// mode register captured by the mode-set command on the address inputs
//
// Behaviour
// - non-mux capture A0-A17 on command edge
// - bit 6 ignored in both modes
// - A5 selects multiplexed address mode
// - A4:A3 encode burst length 2/4/8
// - non-mux config gives rc/rl/wl
// - mux config adds one latency clock
// - mux phases load bits per mapping
// - A7 (phase-two A9 in mux mode) enables DLL, zero holds reset
// - A8 selects external impedance calibration
// - A9 enables on-die termination
`timescale 1ns/1ps
`default_nettype none
module operating_mode_register
  import mode_reg_pkg::*;
(
  input wire logic core_clk, // command clock
  input wire logic rst_b, // synchronous reset, low
  input wire logic mode_set_command, // mode-set decoded this edge
  input wire logic [ADDR_W-1:0] addr_in, // address inputs
  output logic [MODE_W-1:0] mode_bits, // stored mode register
  output logic address_mux_select, // multiplexed addressing
  output logic [3:0] burst_length, // beats per burst
  output logic burst_reserved, // reserved burst code held
  output logic [3:0] row_cycle_time, // clocks
  output logic [3:0] read_latency, // clocks
  output logic [3:0] write_latency, // clocks
  output logic config_reserved, // reserved config code held
  output logic dll_enable, // dll running
  output logic drive_impedance_select, // external calibration
  output logic termination_enable // on-die termination on
);
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PHASE2 = 1'b1
  } cap_state_e;

  cap_state_e state_q, state_d;
  logic [MODE_W-1:0] mode_q, mode_d;
  logic [ADDR_W-1:0] phase1_q;
  logic amux_q;
  logic [3:0] bl_d, rc_d, rl_d, wl_d;
  logic bl_rsvd_d, cfg_rsvd_d;

  wire in_mux = mode_q[AMUX_BIT];
  wire start_single = mode_set_command && !in_mux;
  wire start_mux = mode_set_command && in_mux && state_q == ST_IDLE;
  // non-mux: A0-A17, bit 6 and A18 dropped
  wire [MODE_W-1:0] single_bits = {addr_in[MODE_W-1:UNUSED_BIT+1], 1'b0,
    addr_in[UNUSED_BIT-1:0]};
  // mux: assemble from first phase and the current second phase
  wire [MODE_W-1:0] mux_bits = {8'h00,
    phase1_q[PH1_A9], phase1_q[PH1_A8], addr_in[PH2_A9], 1'b0,
    phase1_q[PH1_A5], phase1_q[PH1_A4], phase1_q[PH1_A3],
    addr_in[PH2_A4], addr_in[PH2_A3], phase1_q[PH1_A0]};

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_single) begin
          mode_d = single_bits;
        end else if (start_mux) begin
          state_d = ST_PHASE2;
        end
      end
      ST_PHASE2: begin
        mode_d = mux_bits;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      mode_q <= MODE_RESET;
      phase1_q <= '0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      if (start_mux) begin
        phase1_q <= addr_in;
      end
    end
  end

  // decode of the stored fields
  wire [1:0] bl_code = mode_q[BL_LSB+1:BL_LSB];
  wire [2:0] cfg_code = mode_q[CFG_LSB+2:CFG_LSB];
  wire [3:0] lat_add = in_mux ? MUX_LAT_ADD : 4'h0;

  always_comb begin
    bl_rsvd_d = 1'b0;
    unique case (bl_code)
      BL_2: bl_d = BURST_2;
      BL_4: bl_d = BURST_4;
      BL_8: bl_d = BURST_8;
      BL_RSVD: begin
        bl_d = BURST_2;
        bl_rsvd_d = 1'b1;
      end
    endcase
  end

  always_comb begin
    cfg_rsvd_d = 1'b0;
    unique case (cfg_code)
      3'h0, 3'h1: rc_d = TRC_C0;
      3'h2: rc_d = TRC_C2;
      3'h3: rc_d = TRC_C3;
      3'h4: rc_d = TRC_C4;
      3'h5: rc_d = TRC_C5;
      3'h6, 3'h7: begin
        rc_d = TRC_C0;
        cfg_rsvd_d = 1'b1;
      end
    endcase
    rl_d = rc_d + lat_add;
    wl_d = rl_d + WL_ADD;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_bits <= MODE_RESET;
      amux_q <= 1'b0;
      burst_length <= BURST_2;
      burst_reserved <= 1'b0;
      row_cycle_time <= TRC_C0;
      read_latency <= TRC_C0;
      write_latency <= TRC_C0 + WL_ADD;
      config_reserved <= 1'b0;
      dll_enable <= 1'b0;
      drive_impedance_select <= 1'b0;
      termination_enable <= 1'b0;
    end else begin
      mode_bits <= mode_q;
      amux_q <= in_mux;
      burst_length <= bl_d;
      burst_reserved <= bl_rsvd_d;
      row_cycle_time <= rc_d;
      read_latency <= rl_d;
      write_latency <= wl_d;
      config_reserved <= cfg_rsvd_d;
      dll_enable <= mode_q[DLL_BIT];
      drive_impedance_select <= mode_q[IMP_BIT];
      termination_enable <= mode_q[TERM_BIT];
    end
  end
  assign address_mux_select = amux_q;

  // capture and storage
  AST_SINGLE_CAPTURE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_single |=> mode_q == $past(single_bits))
    else $error("single-cycle mode-set not captured");
  AST_SINGLE_NO_PHASE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_single |=> state_q == ST_IDLE)
    else $error("single-cycle mode-set entered phase two");
  AST_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_IDLE && !mode_set_command) |=> $stable(mode_q))
    else $error("mode bits changed without a command");
  AST_MODE_OUT: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    mode_bits == $past(mode_q))
    else $error("mode bits output not one cycle behind");
  AST_UNUSED_ZERO: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    mode_q[UNUSED_BIT] == 1'b0)
    else $error("bit 6 stored");

  // two-phase capture
  AST_MUX_START: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> state_q == ST_PHASE2)
    else $error("two-phase mode-set did not wait for phase two");
  AST_MUX_PH2_IGNORED: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    state_q == ST_PHASE2 |=> state_q == ST_IDLE)
    else $error("phase two did not end the mode-set");
  AST_MUX_TWO_PHASE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> ##1 mode_q[PH1_A9] == $past(addr_in[PH1_A9], 2))
    else $error("phase one bit 9 lost");
  AST_MUX_PH1_IMP: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> ##1 mode_q[IMP_BIT] == $past(addr_in[PH1_A8], 2))
    else $error("phase one bit 8 lost");
  AST_MUX_PH1_FIELDS: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> ##1 mode_q[AMUX_BIT:BL_LSB] ==
      $past(addr_in[PH1_A5:PH1_A3], 2))
    else $error("phase one bits 5 to 3 lost");
  AST_MUX_PH1_CFG: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> ##1 mode_q[CFG_LSB] == $past(addr_in[PH1_A0], 2))
    else $error("phase one bit 0 lost");
  AST_MUX_PHASE2: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> ##1 mode_q[DLL_BIT] == $past(addr_in[PH2_A9]))
    else $error("phase two bit 7 lost");
  AST_MUX_PH2_CFG: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> ##1 mode_q[CFG_LSB+2:CFG_LSB+1] ==
      $past(addr_in[PH2_A4:PH2_A3]))
    else $error("phase two bits 2 and 1 lost");
  AST_MUX_UPPER_ZERO: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_mux |=> ##1 mode_q[MODE_W-1:TERM_BIT+1] == 8'h00)
    else $error("two-phase mode-set stored upper bits");

  // burst and address mode decode
  AST_AMUX: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $rose(mode_q[AMUX_BIT]) |=> address_mux_select)
    else $error("address mode not followed");
  AST_AMUX_FALL: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $fell(mode_q[AMUX_BIT]) |=> !address_mux_select)
    else $error("single-phase mode not restored");
  AST_BURST_2: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    bl_code == BL_2 |=> (burst_length == BURST_2 && !burst_reserved))
    else $error("burst length 2 wrong");
  AST_BURST: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    bl_code == BL_4 |=> burst_length == BURST_4)
    else $error("burst length wrong");
  AST_BURST_8: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    bl_code == BL_8 |=> burst_length == BURST_8)
    else $error("burst length 8 wrong");
  AST_BURST_RSVD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    bl_code == BL_RSVD |=> burst_reserved)
    else $error("reserved burst code not flagged");

  // latency configuration decode
  AST_CFG_RSVD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_code[2:1] == 2'h3 |=> config_reserved)
    else $error("reserved configuration not flagged");
  AST_CFG_VALID: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_code[2:1] != 2'h3 |=> !config_reserved)
    else $error("valid configuration flagged");
  AST_RC_C1: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_code == 3'h1 |=> row_cycle_time == TRC_C0)
    else $error("row cycle for code 1 wrong");
  AST_RC_C2: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_code == 3'h2 |=> row_cycle_time == TRC_C2)
    else $error("row cycle for code 2 wrong");
  AST_RC_C3: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_code == 3'h3 |=> row_cycle_time == TRC_C3)
    else $error("row cycle for code 3 wrong");
  AST_RC_C4: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_code == 3'h4 |=> row_cycle_time == TRC_C4)
    else $error("row cycle for code 4 wrong");
  AST_RC_C5: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_code == 3'h5 |=> row_cycle_time == TRC_C5)
    else $error("row cycle for code 5 wrong");
  AST_WL: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    write_latency == read_latency + WL_ADD)
    else $error("write latency not read plus one");
  AST_WL_SINGLE: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!in_mux && cfg_code == 3'h0) |=> write_latency == TRC_C0 + WL_ADD)
    else $error("single-phase write latency wrong");
  AST_SINGLE_LAT: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!in_mux && cfg_code == 3'h5) |=> read_latency == TRC_C5)
    else $error("single-phase read latency wrong");
  AST_MUX_LAT: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (in_mux && cfg_code == 3'h3) |=> read_latency == TRC_C3 + MUX_LAT_ADD)
    else $error("mux latency wrong");
  AST_MUX_LAT_C4: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (in_mux && cfg_code == 3'h4) |=>
      (read_latency == TRC_C4 + MUX_LAT_ADD &&
      write_latency == TRC_C4 + MUX_LAT_ADD + WL_ADD))
    else $error("mux latency for code 4 wrong");

  // feature bits
  AST_FEATURES: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ##1 (dll_enable == $past(mode_q[DLL_BIT]) &&
    termination_enable == $past(mode_q[TERM_BIT]) &&
    drive_impedance_select == $past(mode_q[IMP_BIT])))
    else $error("feature output mismatch");
  AST_DLL_OFF: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !mode_q[DLL_BIT] |=> !dll_enable)
    else $error("dll running while held in reset");
endmodule // operating_mode_register
`default_nettype wire

// [mode_reg_pkg.sv]
// constants for the memory operating mode register
package mode_reg_pkg;
  localparam int ADDR_W = 19;
  localparam int MODE_W = 18;
  // field positions in the mode bits
  localparam int CFG_LSB = 0;
  localparam int BL_LSB = 3;
  localparam int AMUX_BIT = 5;
  localparam int UNUSED_BIT = 6;
  localparam int DLL_BIT = 7;
  localparam int IMP_BIT = 8;
  localparam int TERM_BIT = 9;
  // first phase and second phase input positions in multiplexed mode
  localparam int PH1_A0 = 0;
  localparam int PH1_A3 = 3;
  localparam int PH1_A4 = 4;
  localparam int PH1_A5 = 5;
  localparam int PH1_A8 = 8;
  localparam int PH1_A9 = 9;
  localparam int PH2_A3 = 3;
  localparam int PH2_A4 = 4;
  localparam int PH2_A8 = 8;
  localparam int PH2_A9 = 9;
  localparam logic [17:0] MODE_RESET = 18'h00000;
  localparam logic [1:0] BL_2 = 2'h0;
  localparam logic [1:0] BL_4 = 2'h1;
  localparam logic [1:0] BL_8 = 2'h2;
  localparam logic [1:0] BL_RSVD = 2'h3;
  localparam logic [3:0] BURST_2 = 4'h2;
  localparam logic [3:0] BURST_4 = 4'h4;
  localparam logic [3:0] BURST_8 = 4'h8;
  // row cycle and read latency per configuration code, non-multiplexed
  localparam logic [3:0] TRC_C0 = 4'h4;
  localparam logic [3:0] TRC_C2 = 4'h6;
  localparam logic [3:0] TRC_C3 = 4'h8;
  localparam logic [3:0] TRC_C4 = 4'h3;
  localparam logic [3:0] TRC_C5 = 4'h5;
  localparam logic [3:0] MUX_LAT_ADD = 4'h1;
  localparam logic [3:0] WL_ADD = 4'h1;
endpackage

// [mode_ctl_model.sv]
// controller model that issues mode-set commands on the address pins
`timescale 1ns/1ps
`default_nettype none
module mode_ctl_model
  import mode_reg_pkg::*;
#(
  parameter int RECOVERY = 6
)
(
  input wire logic core_clk, // command clock
  output logic mode_set_command, // one-cycle command strobe
  output logic [ADDR_W-1:0] addr_in // address pins
);
  logic mux_q;
  initial begin
    mode_set_command = 1'b0;
    addr_in = '0;
    mux_q = 1'b0;
  end
  // idle banks only; no bank command or read ever follows
  task automatic set_mode(input logic [9:0] m);
    @(negedge core_clk);
    mode_set_command = 1'b1;
    // top pin high only in single phase, bits 10-17 low
    addr_in = mux_q ? {9'h000, m[9:8], 2'h0, m[5:3], 2'h0, m[0]}
                    : {9'h100, m};
    if (mux_q) begin
      @(negedge core_clk);
      mode_set_command = 1'b0;
      addr_in = {9'h000, m[7:6], 3'h0, m[2:1], 3'h0};
    end
    @(negedge core_clk);
    mode_set_command = 1'b0;
    addr_in = ~addr_in;
    repeat (RECOVERY) @(negedge core_clk);
    mux_q = m[5];
  endtask
endmodule // mode_ctl_model
`default_nettype wire

// [memory_mode_register_bench.sv]
// self-checking bench for the operating mode register
`timescale 1ns/1ps
`default_nettype none
module memory_mode_register_bench;
  import mode_reg_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b;
  logic mode_set_command;
  logic [ADDR_W-1:0] addr_in;
  logic [MODE_W-1:0] mode_bits;
  logic amux, bres, cres, dll, imp, term;
  logic [3:0] bl, rc, rl, wl;
  logic [9:0] m;
  int n_mismatch = 0;
  int comparisons = 0;
  always #2 core_clk = ~core_clk;
  mode_ctl_model mode_ctl_model_inst (.core_clk(core_clk),
    .mode_set_command(mode_set_command), .addr_in(addr_in));
  operating_mode_register operating_mode_register_inst (.core_clk(core_clk),
    .rst_b(rst_b), .mode_set_command(mode_set_command), .addr_in(addr_in),
    .mode_bits(mode_bits), .address_mux_select(amux), .burst_length(bl),
    .burst_reserved(bres), .row_cycle_time(rc), .read_latency(rl),
    .write_latency(wl), .config_reserved(cres), .dll_enable(dll),
    .drive_impedance_select(imp), .termination_enable(term));
  task automatic cmp(input string name, input logic [17:0] e,
                     input logic [17:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_mode(input logic [9:0] v);
    logic [3:0] erc;
    logic [3:0] ebl;
    case (v[2:0])
      3'h2: erc = 4'h6;
      3'h3: erc = 4'h8;
      3'h4: erc = 4'h3;
      3'h5: erc = 4'h5;
      default: erc = 4'h4;
    endcase
    case (v[4:3])
      2'h1: ebl = 4'h4;
      2'h2: ebl = 4'h8;
      default: ebl = 4'h2;
    endcase
    cmp("mode_bits", {8'h00, v[9:7], 1'b0, v[5:0]}, mode_bits);
    cmp("mux_select", 18'(v[5]), 18'(amux));
    cmp("burst", 18'(ebl), 18'(bl));
    cmp("burst_rsvd", 18'(&v[4:3]), 18'(bres));
    cmp("row_cycle", 18'(erc), 18'(rc));
    cmp("read_lat", 18'(erc) + 18'(v[5]), 18'(rl));
    cmp("write_lat", 18'(erc) + 18'(v[5]) + 18'h1, 18'(wl));
    cmp("cfg_rsvd", 18'(v[2] & v[1]), 18'(cres));
    cmp("dll", 18'(v[7]), 18'(dll));
    cmp("impedance", 18'(v[8]), 18'(imp));
    cmp("termination", 18'(v[9]), 18'(term));
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    check_mode(10'h000);
    $display("test reset defaults done");
    // 0-7 single phase, 8 enters mux, 9-15 two phase
    for (int i = 0; i < 16; i++) begin
      m = {i[2:0], 1'b1, i[3], i[1:0], i[2:0]};
      mode_ctl_model_inst.set_mode(m);
      check_mode(m);
    end
    $display("test codes in both modes done");
    mode_ctl_model_inst.set_mode(10'h000);
    check_mode(10'h000);
    $display("test return to single phase done");
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
endmodule // memory_mode_register_bench
`default_nettype wire
